// >>> core/usbsdc_top.sv
// Purpose: usb supply section control: source, switch, enables, detection
// Assumes: all pins and software strobes synchronous to clock_in
// Notes: software writes arrive as one-cycle strobes with data
`timescale 1ns/1ps
`default_nettype none
module usbsdc_top
  import usbsdc_pkg::*;
#(
  parameter int BUSV_RISE = BUSV_RISE_CYC,
  parameter int BUSV_FALL = BUSV_FALL_CYC,
  parameter int SESS_RISE = SESS_RISE_CYC,
  parameter int SESS_FALL = SESS_FALL_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // pins
  input wire logic strap_supply_config_in,
  input wire logic system_reset_n_in,
  input wire logic bus_drive_enable_pin_in,
  // comparators
  input wire logic bus_valid_cmp_in,
  input wire logic session_valid_cmp_in,
  input wire logic overvoltage_cmp_in,
  input wire logic [2:0] id_cmp_in,
  // software writes
  input wire logic otg_supply_select_wr_in,
  input wire logic otg_supply_select_in,
  input wire logic main_usb_reg_enable_wr_in,
  input wire logic main_usb_reg_enable_in,
  input wire logic boost_enable_bit_wr_in,
  input wire logic boost_enable_bit_in,
  input wire logic aux_usb_reg_enable_wr_in,
  input wire logic aux_usb_reg_enable_in,
  input wire logic aux_usb_reg_level_wr_in,
  input wire logic [1:0] aux_usb_reg_level_in,
  input wire logic id_pullup_type_in,
  input wire logic id_extra_pullup_in,
  input wire logic [IRQ_NUM-1:0] irq_mask_in,
  input wire logic [IRQ_NUM-1:0] irq_clear_in,
  // supply controls
  output logic phy_supply_from_boost_out,
  output logic usb_phy_supply_en_out,
  output logic bus_switch_close_out,
  output logic boost_supply_en_out,
  output logic aux_usb_reg_en_out,
  output logic [1:0] aux_usb_reg_level_out,
  // id pull-ups
  output logic id_current_source_en_out,
  output logic id_resistor_pullup_en_out,
  output logic id_extra_pullup_en_out,
  // readable state
  output logic otg_supply_select_out,
  output logic main_usb_reg_enable_out,
  output logic boost_enable_bit_out,
  output logic bus_valid_sense_out,
  output logic session_valid_sense_out,
  output logic overvoltage_sense_out,
  output logic id_float_sense_out,
  output logic id_ground_sense_out,
  output logic id_factory_sense_out,
  // interrupts
  output logic [IRQ_NUM-1:0] irq_pending_out,
  output logic irq_out
);
  generate
    if (OVP_PATH_CYC > OVP_DISC_CYC || OVP_PATH_CYC < 1) begin : g_ovp_chk
      $error("over-voltage path slower than the disconnect limit");
    end
  endgenerate

  usbsdc_state_t state_q;
  logic otg_sel_q;
  logic main_en_q;
  logic boost_en_q;
  logic aux_en_q;
  logic [1:0] aux_level_q;
  logic strap_open_q;
  logic rstn_prev_q;
  logic ovp_q;
  logic ovp_chg_q;
  logic phy_en_q;
  logic switch_q;
  logic [IRQ_NUM-1:0] pend_q;
  logic [IRQ_NUM-1:0] events;
  logic irq_q;
  logic sense_busv_q;
  logic sense_sess_q;
  logic [ID_W-1:0] sense_id_q;
  logic pu_cur_q;
  logic pu_res_q;
  logic pu_extra_q;
  logic cold;
  logic otg_set;
  logic force_main;
  logic busv_fall;
  logic rstn_rise;

  usbsdc_sense_if #(.W(1)) busv_if ();
  usbsdc_sense_if #(.W(1)) sess_if ();
  usbsdc_sense_if #(.W(ID_W)) id_if ();

  // comparator levels into the qualifiers
  assign busv_if.raw = bus_valid_cmp_in;
  assign sess_if.raw = session_valid_cmp_in;
  assign id_if.raw = id_cmp_in;

  // bus-valid qualifier
  usbsdc_debounce #(
    .RISE_CYC(BUSV_RISE),
    .FALL_CYC(BUSV_FALL),
    .CNT_W(DEB_CNT_W)
  ) u_busv (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .det(busv_if.src)
  );

  // session-valid qualifier
  usbsdc_debounce #(
    .RISE_CYC(SESS_RISE),
    .FALL_CYC(SESS_FALL),
    .CNT_W(DEB_CNT_W)
  ) u_sess (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .det(sess_if.src)
  );

  // id pin decode
  usbsdc_id_decode u_id (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .id(id_if.src)
  );

  // cold start: strap is read on the second edge after release
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_STRAP;
        end
        ST_STRAP: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign cold = (state_q == ST_STRAP);
  assign otg_set = otg_supply_select_wr_in && otg_supply_select_in && !cold;
  assign rstn_rise = system_reset_n_in && !rstn_prev_q;
  assign busv_fall = busv_if.change[0] && !busv_if.sense[0];
  assign force_main = strap_open_q && (rstn_rise || busv_fall) && !cold;

  // strap memory and reset pin edge
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_open_q <= 1'b0;
      rstn_prev_q <= 1'b0;
    end else begin
      rstn_prev_q <= system_reset_n_in;
      if (cold) begin
        strap_open_q <= (strap_supply_config_in != STRAP_GROUNDED);
      end
    end
  end

  // supply source select
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      otg_sel_q <= RST_OTG_SEL;
    end else if (cold) begin
      otg_sel_q <= (strap_supply_config_in == STRAP_GROUNDED);
    end else if (otg_supply_select_wr_in) begin
      otg_sel_q <= otg_supply_select_in;
    end
  end

  // boost enable, set by default with a grounded strap
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      boost_en_q <= RST_BOOST_EN;
    end else if (cold) begin
      boost_en_q <= (strap_supply_config_in == STRAP_GROUNDED);
    end else if (boost_enable_bit_wr_in) begin
      boost_en_q <= boost_enable_bit_in;
    end
  end

  // main regulator enable; the forced set beats a software clear
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_en_q <= RST_MAIN_EN;
    end else if (cold) begin
      main_en_q <= 1'b1;
    end else if (force_main) begin
      main_en_q <= 1'b1;
    end else if (otg_set) begin
      main_en_q <= 1'b1;
    end else if (main_usb_reg_enable_wr_in) begin
      main_en_q <= main_usb_reg_enable_in;
    end
  end

  // auxiliary regulator enable and level
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aux_en_q <= RST_AUX_EN;
      aux_level_q <= RST_AUX_LEVEL;
    end else begin
      if (otg_set) begin
        aux_en_q <= 1'b1;
      end else if (aux_usb_reg_enable_wr_in) begin
        aux_en_q <= aux_usb_reg_enable_in;
      end
      if (aux_usb_reg_level_wr_in) begin
        aux_level_q <= aux_usb_reg_level_in;
      end
    end
  end

  // over-voltage level and its change event
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ovp_q <= 1'b0;
      ovp_chg_q <= 1'b0;
    end else begin
      ovp_q <= overvoltage_cmp_in;
      ovp_chg_q <= overvoltage_cmp_in ^ ovp_q;
    end
  end

  // phy supply and bus switch, over-voltage cuts both in one cycle
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phy_en_q <= 1'b0;
      switch_q <= 1'b0;
    end else begin
      phy_en_q <= main_en_q && !overvoltage_cmp_in
                  && (otg_sel_q || busv_if.sense[0]);
      switch_q <= bus_drive_enable_pin_in && otg_sel_q
                  && !overvoltage_cmp_in;
    end
  end

  // id pull-up controls
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pu_cur_q <= 1'b0;
      pu_res_q <= 1'b0;
      pu_extra_q <= 1'b0;
    end else begin
      pu_cur_q <= id_pullup_type_in;
      pu_res_q <= !id_pullup_type_in;
      pu_extra_q <= id_extra_pullup_in;
    end
  end

  // readable sense copies
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sense_busv_q <= 1'b0;
      sense_sess_q <= 1'b0;
      sense_id_q <= '0;
    end else begin
      sense_busv_q <= busv_if.sense[0];
      sense_sess_q <= sess_if.sense[0];
      sense_id_q <= id_if.sense;
    end
  end

  // event vector, not gated by otg mode
  always_comb begin
    events = '0;
    events[IRQ_BUSV] = busv_if.change[0];
    events[IRQ_SESS] = sess_if.change[0];
    events[IRQ_OVP] = ovp_chg_q;
    events[IRQ_ID_BASE+ID_FLOAT_BIT] = id_if.change[ID_FLOAT_BIT];
    events[IRQ_ID_BASE+ID_GROUND_BIT] = id_if.change[ID_GROUND_BIT];
    events[IRQ_ID_BASE+ID_FACTORY_BIT] = id_if.change[ID_FACTORY_BIT];
  end

  // pending flags, a new event wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_NUM; gi++) begin : g_pend
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          pend_q[gi] <= 1'b0;
        end else if (events[gi]) begin
          pend_q[gi] <= 1'b1;
        end else if (irq_clear_in[gi]) begin
          pend_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // masked interrupt line
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(pend_q & ~irq_mask_in);
    end
  end

  // outputs, all from flip-flops
  assign phy_supply_from_boost_out = otg_sel_q;
  assign usb_phy_supply_en_out = phy_en_q;
  assign bus_switch_close_out = switch_q;
  assign boost_supply_en_out = boost_en_q;
  assign aux_usb_reg_en_out = aux_en_q;
  assign aux_usb_reg_level_out = aux_level_q;
  assign id_current_source_en_out = pu_cur_q;
  assign id_resistor_pullup_en_out = pu_res_q;
  assign id_extra_pullup_en_out = pu_extra_q;
  assign otg_supply_select_out = otg_sel_q;
  assign main_usb_reg_enable_out = main_en_q;
  assign boost_enable_bit_out = boost_en_q;
  assign bus_valid_sense_out = sense_busv_q;
  assign session_valid_sense_out = sense_sess_q;
  assign overvoltage_sense_out = ovp_q;
  assign id_float_sense_out = sense_id_q[ID_FLOAT_BIT];
  assign id_ground_sense_out = sense_id_q[ID_GROUND_BIT];
  assign id_factory_sense_out = sense_id_q[ID_FACTORY_BIT];
  assign irq_pending_out = pend_q;
  assign irq_out = irq_q;
endmodule
`default_nettype wire

// >>> include/usbsdc_pkg.sv
// Purpose: shared constants for the usb supply and detect control block
// Assumes: one 200 MHz clock
// Notes: times are kept in their own units, cycle counts derive from them
package usbsdc_pkg;
  // clock rate
  localparam int CLK_FREQ_KHZ = 200000;
  // comparator debounce times, least values of each window
  localparam int BUSV_RISE_MS = 20;
  localparam int BUSV_FALL_MS = 8;
  localparam int SESS_RISE_MS = 20;
  localparam int SESS_FALL_MS = 8;
  localparam int BUSV_RISE_CYC = BUSV_RISE_MS * CLK_FREQ_KHZ;
  localparam int BUSV_FALL_CYC = BUSV_FALL_MS * CLK_FREQ_KHZ;
  localparam int SESS_RISE_CYC = SESS_RISE_MS * CLK_FREQ_KHZ;
  localparam int SESS_FALL_CYC = SESS_FALL_MS * CLK_FREQ_KHZ;
  localparam int DEB_CNT_W = 23;
  // over-voltage disconnect limit, longest time rounds down
  localparam int OVP_DISC_NS = 1000;
  localparam int OVP_DISC_CYC = OVP_DISC_NS * CLK_FREQ_KHZ / 1000000;
  localparam int OVP_PATH_CYC = 1;
  // strap level that means grounded
  localparam logic STRAP_GROUNDED = 1'b0;
  // reset values of control state
  localparam logic RST_OTG_SEL = 1'b0;
  localparam logic RST_MAIN_EN = 1'b0;
  localparam logic RST_BOOST_EN = 1'b0;
  localparam logic RST_AUX_EN = 1'b0;
  localparam logic [1:0] RST_AUX_LEVEL = 2'h0;
  // id sense bit positions
  localparam int ID_W = 3;
  localparam int ID_FLOAT_BIT = 0;
  localparam int ID_GROUND_BIT = 1;
  localparam int ID_FACTORY_BIT = 2;
  // interrupt source positions
  localparam int IRQ_BUSV = 0;
  localparam int IRQ_SESS = 1;
  localparam int IRQ_OVP = 2;
  localparam int IRQ_ID_BASE = 3;
  localparam int IRQ_NUM = 6;
  // cold start sequence
  typedef enum logic [1:0] {ST_IDLE, ST_STRAP, ST_RUN} usbsdc_state_t;
endpackage

// >>> include/usbsdc_sense_if.sv
// Purpose: carries a raw comparator level, its qualified sense and change
// Assumes: one clock domain
// Notes: change is a one-cycle pulse beside each sense bit
`timescale 1ns/1ps
`default_nettype none
interface usbsdc_sense_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sense;
  logic [W-1:0] change;
  // qualifier side
  modport src(input raw, output sense, output change);
  // user side
  modport snk(output raw, input sense, input change);
endinterface
`default_nettype wire

// >>> core/usbsdc_debounce.sv
// Purpose: debounces one comparator level with separate rise and fall times
// Assumes: raw is synchronous to clock_in
// Notes: sense moves after raw has held its new level the full time
`timescale 1ns/1ps
`default_nettype none
module usbsdc_debounce
  import usbsdc_pkg::*;
#(
  parameter int RISE_CYC = BUSV_RISE_CYC,
  parameter int FALL_CYC = BUSV_FALL_CYC,
  parameter int CNT_W = DEB_CNT_W
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // comparator
  usbsdc_sense_if.src det
);
  localparam logic [CNT_W-1:0] RISE_LAST = CNT_W'(RISE_CYC - 1);
  localparam logic [CNT_W-1:0] FALL_LAST = CNT_W'(FALL_CYC - 1);
  generate
    if (RISE_CYC < 1 || FALL_CYC < 1 || RISE_CYC > 2**CNT_W || FALL_CYC > 2**CNT_W) begin : g_chk
      $error("debounce count does not fit the counter");
    end
  endgenerate
  logic [CNT_W-1:0] cnt_q;
  logic sense_q;
  logic chg_q;
  logic done;
  assign done = (cnt_q == (sense_q ? FALL_LAST : RISE_LAST));
  // stability counter, cleared whenever raw agrees with sense
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
    end else if (det.raw[0] == sense_q || done) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  // qualified level and its change pulse
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sense_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      chg_q <= (det.raw[0] != sense_q) && done;
      if (det.raw[0] != sense_q && done) begin
        sense_q <= det.raw[0];
      end
    end
  end
  assign det.sense[0] = sense_q;
  assign det.change[0] = chg_q;
endmodule
`default_nettype wire

// >>> core/usbsdc_id_decode.sv
// Purpose: decodes the id pin threshold comparators into three sense bits
// Assumes: comparator levels are synchronous to clock_in
// Notes: raw bits are low, high and factory thresholds, in that order
`timescale 1ns/1ps
`default_nettype none
module usbsdc_id_decode
  import usbsdc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // comparators in, sense out
  usbsdc_sense_if.src id
);
  logic [ID_W-1:0] dec;
  logic [ID_W-1:0] sense_q;
  logic [ID_W-1:0] chg_q;
  // resistor 0,1,0; grounded 0,0,0; floating 1,1,0; voltage 1,1,1
  always_comb begin
    dec[ID_FACTORY_BIT] = id.raw[2];
    dec[ID_FLOAT_BIT] = id.raw[1] | id.raw[2];
    dec[ID_GROUND_BIT] = id.raw[0] | id.raw[1] | id.raw[2];
  end
  // registered sense with per-bit change pulses
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sense_q <= '0;
      chg_q <= '0;
    end else begin
      sense_q <= dec;
      chg_q <= dec ^ sense_q;
    end
  end
  assign id.sense = sense_q;
  assign id.change = chg_q;
endmodule
`default_nettype wire

// >>> tb/usbsdc_cable.sv
// Purpose: far-side model of the usb cable peer seen through the detect comparators
// Assumes: levels settle before the block samples them
// Notes: one plug kind code picks how many id thresholds the pin clears
`timescale 1ns/1ps
`default_nettype none
module usbsdc_cable
  import usbsdc_pkg::*;
(
  // stimulus from the bench
  input wire logic cable_on_in,
  input wire logic [1:0] id_kind_in,
  // comparator levels toward the block
  output logic bus_valid_cmp_out,
  output logic session_valid_cmp_out,
  output logic [ID_W-1:0] id_cmp_out
);
  // a powered cable lifts both bus comparators together
  assign bus_valid_cmp_out = cable_on_in;
  assign session_valid_cmp_out = cable_on_in;
  // plug kind sets the id pin voltage band
  always_comb begin
    case (id_kind_in)
      2'h0: id_cmp_out = 3'h0; // grounded plug
      2'h1: id_cmp_out = 3'h1; // resistor to ground
      2'h2: id_cmp_out = 3'h3; // floating pin
      default: id_cmp_out = 3'h7; // voltage applied
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/usbsdc_checker.sv
// Purpose: port-level checks for the usb supply and detect control block
// Assumes: bound into usbsdc_top, one clock domain
// Notes: debounce checks count cycles since the raw level last moved
`timescale 1ns/1ps
`default_nettype none
module usbsdc_checker
  import usbsdc_pkg::*;
#(
  parameter int BUSV_RISE = BUSV_RISE_CYC,
  parameter int BUSV_FALL = BUSV_FALL_CYC,
  parameter int SESS_RISE = SESS_RISE_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // watched inputs
  input wire logic bus_drive_enable_pin_in,
  input wire logic bus_valid_cmp_in,
  input wire logic session_valid_cmp_in,
  input wire logic overvoltage_cmp_in,
  input wire logic [2:0] id_cmp_in,
  input wire logic otg_supply_select_wr_in,
  input wire logic otg_supply_select_in,
  input wire logic aux_usb_reg_level_wr_in,
  input wire logic [1:0] aux_usb_reg_level_in,
  input wire logic [IRQ_NUM-1:0] irq_mask_in,
  // watched outputs
  input wire logic phy_supply_from_boost_out,
  input wire logic usb_phy_supply_en_out,
  input wire logic bus_switch_close_out,
  input wire logic boost_supply_en_out,
  input wire logic aux_usb_reg_en_out,
  input wire logic [1:0] aux_usb_reg_level_out,
  input wire logic otg_supply_select_out,
  input wire logic main_usb_reg_enable_out,
  input wire logic boost_enable_bit_out,
  input wire logic bus_valid_sense_out,
  input wire logic session_valid_sense_out,
  input wire logic overvoltage_sense_out,
  input wire logic id_float_sense_out,
  input wire logic id_ground_sense_out,
  input wire logic id_factory_sense_out,
  input wire logic [IRQ_NUM-1:0] irq_pending_out,
  input wire logic irq_out
);
  logic [1:0] run_q;
  logic bv_q;
  logic sv_q;
  logic [7:0] bv_cnt_q;
  logic [7:0] sv_cnt_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // cycles since reset release and since each raw level last moved
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      run_q <= 2'h0;
      bv_q <= 1'h0;
      sv_q <= 1'h0;
      bv_cnt_q <= 8'h0;
      sv_cnt_q <= 8'h0;
    end else begin
      run_q <= run_q + {1'h0, run_q != 2'h3};
      bv_q <= bus_valid_cmp_in;
      sv_q <= session_valid_cmp_in;
      bv_cnt_q <= (bus_valid_cmp_in != bv_q) ? 8'h0 : bv_cnt_q + {7'h0, bv_cnt_q != 8'hff};
      sv_cnt_q <= (session_valid_cmp_in != sv_q) ? 8'h0 : sv_cnt_q + {7'h0, sv_cnt_q != 8'hff};
    end
  end
  sw_gate_a: assert property (bus_switch_close_out |-> $past(bus_drive_enable_pin_in)
    && (otg_supply_select_out || $past(otg_supply_select_out))) else $error("switch closed");
  feed_sel_a: assert property (phy_supply_from_boost_out == otg_supply_select_out)
    else $error("phy feed differs from select");
  boost_bit_a: assert property (boost_supply_en_out == boost_enable_bit_out)
    else $error("boost differs from its bit");
  otg_auto_a: assert property (run_q == 2'h3 && otg_supply_select_wr_in && otg_supply_select_in
    |=> otg_supply_select_out && main_usb_reg_enable_out && aux_usb_reg_en_out)
    else $error("otg select did not enable regulators");
  phy_gate_a: assert property (usb_phy_supply_en_out |-> $past(main_usb_reg_enable_out)
    && !$past(overvoltage_cmp_in)) else $error("phy supply on without cause");
  ovp_cut_a: assert property (overvoltage_cmp_in |=> !usb_phy_supply_en_out
    && !bus_switch_close_out && overvoltage_sense_out) else $error("over-voltage not cut");
  ovp_flag_a: assert property ($rose(overvoltage_sense_out) |=> irq_pending_out[IRQ_OVP])
    else $error("over-voltage event not pending");
  aux_code_a: assert property (run_q == 2'h3 && aux_usb_reg_level_wr_in
    |=> aux_usb_reg_level_out == $past(aux_usb_reg_level_in)) else $error("aux code wrong");
  id_decode_a: assert property (run_q == 2'h3 |-> id_factory_sense_out == $past(id_cmp_in[2], 2)
    && id_ground_sense_out == |$past(id_cmp_in, 2)
    && id_float_sense_out == |$past(id_cmp_in[2:1], 2)) else $error("id decode wrong");
  irq_gate_a: assert property (irq_out == $past(|(irq_pending_out & ~irq_mask_in)))
    else $error("irq not pending and unmasked");
  bv_rise_a: assert property ($rose(bus_valid_sense_out) |-> bus_valid_cmp_in
    && bv_cnt_q >= BUSV_RISE - 1 && bv_cnt_q <= BUSV_RISE + 1) else $error("bus rise time");
  bv_fall_a: assert property ($fell(bus_valid_sense_out) |-> !bus_valid_cmp_in
    && bv_cnt_q >= BUSV_FALL - 1 && bv_cnt_q <= BUSV_FALL + 1) else $error("bus fall time");
  sv_rise_a: assert property ($rose(session_valid_sense_out) |-> session_valid_cmp_in
    && sv_cnt_q >= SESS_RISE - 1 && sv_cnt_q <= SESS_RISE + 1) else $error("session rise time");
endmodule
bind usbsdc_top usbsdc_checker #(.BUSV_RISE(BUSV_RISE), .BUSV_FALL(BUSV_FALL),
  .SESS_RISE(SESS_RISE)) chk (.*);
`default_nettype wire

// >>> tb/tb_usb_supply_detect_control.sv
// Purpose: self-checking bench for the usb supply and detect control block
// Assumes: inputs change at the falling edge, short debounce counts
// Notes: writes are one-cycle strobes sharing one data bus
`timescale 1ns/1ps
`default_nettype none
module tb_usb_supply_detect_control;
  import usbsdc_pkg::*;
  localparam int BR = 20;
  localparam int BF = 8;
  localparam int SR = 30;
  localparam int SF = 10;
  logic clock_in, sys_rst_in, strap_supply_config_in, system_reset_n_in;
  logic bus_drive_enable_pin_in, overvoltage_cmp_in, cable_on, id_pullup_type_in;
  logic id_extra_pullup_in;
  logic [1:0] id_kind;
  logic [4:0] wr_stb;
  logic [1:0] wr_dat;
  logic [5:0] irq_mask_in, irq_clear_in;
  wire logic bus_valid_cmp_in, session_valid_cmp_in;
  wire logic [2:0] id_cmp_in;
  logic phy_supply_from_boost_out, usb_phy_supply_en_out, bus_switch_close_out;
  logic boost_supply_en_out, aux_usb_reg_en_out, id_current_source_en_out;
  logic id_resistor_pullup_en_out, id_extra_pullup_en_out, otg_supply_select_out;
  logic main_usb_reg_enable_out, boost_enable_bit_out, bus_valid_sense_out;
  logic session_valid_sense_out, overvoltage_sense_out, id_float_sense_out;
  logic id_ground_sense_out, id_factory_sense_out, irq_out;
  logic [1:0] aux_usb_reg_level_out;
  logic [5:0] irq_pending_out;
  logic [2:0] id_tab [4];
  logic [2:0] prev;
  int fail_count;
  int checked;
  usbsdc_cable peer (.cable_on_in(cable_on), .id_kind_in(id_kind),
    .bus_valid_cmp_out(bus_valid_cmp_in), .session_valid_cmp_out(session_valid_cmp_in),
    .id_cmp_out(id_cmp_in));
  usbsdc_top #(.BUSV_RISE(BR), .BUSV_FALL(BF), .SESS_RISE(SR), .SESS_FALL(SF)) dut (.*,
    .otg_supply_select_wr_in(wr_stb[0]), .otg_supply_select_in(wr_dat[0]),
    .main_usb_reg_enable_wr_in(wr_stb[1]), .main_usb_reg_enable_in(wr_dat[0]),
    .boost_enable_bit_wr_in(wr_stb[2]), .boost_enable_bit_in(wr_dat[0]),
    .aux_usb_reg_enable_wr_in(wr_stb[3]), .aux_usb_reg_enable_in(wr_dat[0]),
    .aux_usb_reg_level_wr_in(wr_stb[4]), .aux_usb_reg_level_in(wr_dat));
  // 200 MHz clock
  always #2.5 clock_in = ~clock_in;
  // compare one value and count it
  task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // one write strobe: 0 otg select, 1 main enable, 2 boost, 3 aux enable, 4 aux level
  task automatic wr(input int sel, input logic [1:0] v);
    wr_dat = v;
    wr_stb = 5'h1 << sel;
    cyc(1);
    wr_stb = 5'h0;
    cyc(1);
  endtask
  // reset with a given strap level, then let the cold start load land
  task automatic boot(input logic strap);
    sys_rst_in = 1'h1;
    strap_supply_config_in = strap;
    cyc(5);
    sys_rst_in = 1'h0;
    cyc(4);
  endtask
  task automatic complete_run();
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // cut a hang short well past the expected run length
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end
  // main sequence
  initial begin
    {clock_in, system_reset_n_in, bus_drive_enable_pin_in, overvoltage_cmp_in} = 4'h4;
    {cable_on, id_pullup_type_in, id_extra_pullup_in, id_kind, wr_dat} = 7'h0;
    {wr_stb, irq_mask_in, irq_clear_in} = 17'h0;
    id_tab = '{3'h0, 3'h2, 3'h3, 3'h7};
    fail_count = 0;
    checked = 0;
    boot(1'h1);
    chk("open strap select", 6'h0, otg_supply_select_out);
    chk("open strap main", 6'h1, main_usb_reg_enable_out);
    chk("open strap phy", 6'h0, usb_phy_supply_en_out);
    cable_on = 1'h1;
    cyc(5);
    cable_on = 1'h0;
    cyc(BR + 5);
    chk("glitch sense", 6'h0, bus_valid_sense_out);
    cable_on = 1'h1;
    cyc(SR + 4);
    chk("senses", 6'h3, {session_valid_sense_out, bus_valid_sense_out});
    chk("cable phy", 6'h2, {usb_phy_supply_en_out, phy_supply_from_boost_out});
    chk("pending", 6'h3, irq_pending_out);
    chk("irq", 6'h1, irq_out);
    irq_mask_in = 6'h3f;
    cyc(2);
    chk("masked irq", 6'h0, irq_out);
    irq_clear_in = 6'h3f;
    cyc(1);
    {irq_clear_in, irq_mask_in} = 12'h0;
    cyc(1);
    chk("cleared", 6'h0, irq_pending_out);
    wr(1, 2'h0);
    chk("main off phy", 6'h0, usb_phy_supply_en_out);
    wr(0, 2'h0);
    wr(1, 2'h1);
    cyc(1);
    chk("main on phy", 6'h1, usb_phy_supply_en_out);
    wr(1, 2'h0);
    system_reset_n_in = 1'h0;
    cyc(2);
    system_reset_n_in = 1'h1;
    cyc(3);
    chk("reset pin force", 6'h1, main_usb_reg_enable_out);
    wr(1, 2'h0);
    cable_on = 1'h0;
    cyc(SF + 4);
    chk("fall senses", 6'h0, {session_valid_sense_out, bus_valid_sense_out});
    chk("bus loss force", 6'h2, {main_usb_reg_enable_out, usb_phy_supply_en_out});
    wr(2, 2'h1);
    bus_drive_enable_pin_in = 1'h1;
    cyc(2);
    chk("boost on", 6'h2, {boost_supply_en_out, bus_switch_close_out});
    wr(0, 2'h1);
    cyc(1);
    chk("otg auto", 6'hf, {otg_supply_select_out, main_usb_reg_enable_out,
      aux_usb_reg_en_out, phy_supply_from_boost_out});
    chk("otg switch phy", 6'h3, {bus_switch_close_out, usb_phy_supply_en_out});
    wr(2, 2'h0);
    chk("boost off", 6'h1, {boost_supply_en_out, bus_switch_close_out});
    bus_drive_enable_pin_in = 1'h0;
    cyc(2);
    chk("drive low", 6'h0, bus_switch_close_out);
    bus_drive_enable_pin_in = 1'h1;
    cyc(2);
    overvoltage_cmp_in = 1'h1;
    @(posedge clock_in);
    #1;
    chk("ovp cut", 6'h0, {usb_phy_supply_en_out, bus_switch_close_out});
    cyc(3);
    chk("ovp event", 6'h3, {irq_pending_out[IRQ_OVP], irq_out});
    overvoltage_cmp_in = 1'h0;
    for (int i = 0; i < 4; i++) begin
      wr(4, i[1:0]);
      chk("aux level", {4'h0, i[1:0]}, aux_usb_reg_level_out);
      wr(3, i[1:0]);
      chk("aux enable", {5'h0, i[0]}, aux_usb_reg_en_out);
    end
    for (int i = 0; i < 4; i++) begin
      {id_extra_pullup_in, id_pullup_type_in} = i[1:0];
      cyc(2);
      chk("pull-ups", {3'h0, i[0], ~i[0], i[1]}, {id_current_source_en_out,
        id_resistor_pullup_en_out, id_extra_pullup_en_out});
    end
    prev = 3'h0;
    for (int j = 1; j < 5; j++) begin
      irq_clear_in = 6'h38;
      cyc(1);
      irq_clear_in = 6'h0;
      id_kind = j[1:0];
      cyc(4);
      chk("id senses", {3'h0, id_tab[j % 4]}, {id_factory_sense_out,
        id_ground_sense_out, id_float_sense_out});
      chk("id events", {3'h0, id_tab[j % 4] ^ prev}, irq_pending_out[5:3]);
      prev = id_tab[j % 4];
    end
    boot(1'h0);
    chk("ground strap", 6'h1f, {otg_supply_select_out, boost_supply_en_out,
      main_usb_reg_enable_out, phy_supply_from_boost_out, usb_phy_supply_en_out});
    cable_on = 1'h1;
    cyc(BR + 4);
    chk("otg bus event", 6'h7, {bus_valid_sense_out, irq_pending_out[IRQ_BUSV],
      phy_supply_from_boost_out});
    complete_run();
  end
endmodule
`default_nettype wire
